/* File: verilog/opcode_field_decoder.sv */
/*
  Decoder for opcode groups 0100 (system, moves, jumps), 0101 and 0110.
  Assumes the fetch pipeline presents opcode and extension words in order,
  one per cycle with word_valid_i high.
*/
`timescale 1ns/1ps
module opcode_field_decoder (
  input  wire logic                 ref_clk_i,    // Clock, 125 MHz
  input  wire logic                 resetn_i,     // Async reset, active low
  input  wire logic                 word_valid_i, // Fetch word valid
  input  wire logic [15:0]          word_i,       // Fetch word
  output logic                      word_ready_o, // Decoder takes words
  output logic                      op_valid_o,   // Decoded opcode pulse
  output logic [15:0]               op_word_o,    // Opcode word
  output logic                      halt_o,       // Halt with immediate
  output logic                      exc_return_o, // Exception return
  output logic                      sub_return_o, // Subroutine return
  output logic                      overflow_trap_o, // Overflow trap
  output logic                      return_restore_flags_o, // Return, restore flags
  output logic                      control_register_move_o, // Control reg move
  output logic                      subroutine_jump_o, // Subroutine jump
  output logic                      unconditional_jump_o, // Jump
  output logic                      quick_add_o,  // Quick add
  output logic                      quick_subtract_o, // Quick subtract
  output logic                      cond_set_o,   // Conditional set
  output logic                      decrement_branch_loop_o, // Decrement and branch
  output logic                      conditional_trap_o, // Conditional trap
  output logic                      cond_branch_o, // Conditional branch
  output logic                      illegal_o,    // Unknown or bad field
  output logic [3:0]                condition_o,  // Condition field
  output logic [3:0]                quick_data_o, // Quick immediate 1..8
  output opdec_pkg::op_size_t       quick_size_o, // Quick operand size
  output logic [5:0]                ea_o,         // Mode and register field
  output logic                      direction_bit_o, // 1: general to control
  output opdec_pkg::ctl_reg_t       ctl_reg_o,    // Selected control register
  output logic [3:0]                gen_reg_o,    // General register, A/D first
  output logic [1:0]                ext_words_o,  // Extension words needed, control move word not counted
  output logic                      ext_valid_o,  // Extension data pulse
  output logic [31:0]               ext_data_o    // Extension word or long
);
  opdec_if dec ();

  opcode_field_match u_match (
    .word_i (word_i),
    .dec    (dec)
  );

  opdec_pkg::dec_state_t state_q, state_d;
  logic [31:0] ext_q;
  logic        hold_long_q;

  // ==========================================================
  // Word acceptance and decode strobes
  wire take       = word_valid_i;
  wire in_opcode  = (state_q == opdec_pkg::ST_OPCODE);
  wire op_take    = take && in_opcode;
  wire any_known  = dec.halt || dec.exc_return || dec.sub_return || dec.overflow_trap
                    || dec.return_restore_flags || dec.control_register_move
                    || dec.subroutine_jump || dec.unconditional_jump || dec.quick_add
                    || dec.quick_subtract || dec.cond_set || dec.decrement_branch_loop
                    || dec.conditional_trap || dec.cond_branch;
  wire [4:0] q_pat = {2'h0, word_i[11:9]};
  wire [3:0] q_val = (word_i[11:9] == opdec_pkg::QUICK_EIGHT_PAT)
                     ? opdec_pkg::QUICK_EIGHT_VAL : q_pat[3:0];
  assign word_ready_o = 1'b1;

  // ==========================================================
  // Control register selection from the extension word
  wire [11:0] cr_code = word_i[11:0];
  opdec_pkg::ctl_reg_t cr_sel;
  always_comb begin
    unique case (cr_code)
      opdec_pkg::CR_SFC_CODE:   cr_sel = opdec_pkg::CR_SRC_FC;
      opdec_pkg::CR_DFC_CODE:   cr_sel = opdec_pkg::CR_DST_FC;
      opdec_pkg::CR_CACHE_CODE: cr_sel = opdec_pkg::CR_CACHE;
      opdec_pkg::CR_USP_CODE:   cr_sel = opdec_pkg::CR_USER_SP;
      opdec_pkg::CR_VBR_CODE:   cr_sel = opdec_pkg::CR_VEC_BASE;
      opdec_pkg::CR_CACHE_ADDRESS_CODE:  cr_sel = opdec_pkg::CR_CACHE_ADR;
      opdec_pkg::CR_MSP_CODE:   cr_sel = opdec_pkg::CR_MASTER_SP;
      opdec_pkg::CR_ISP_CODE:   cr_sel = opdec_pkg::CR_INT_SP;
      default:                  cr_sel = opdec_pkg::CR_ILLEGAL;
    endcase
  end

  // ==========================================================
  // Sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      opdec_pkg::ST_OPCODE: begin
        if (take && dec.control_register_move) begin
          state_d = opdec_pkg::ST_CREXT;
        end else if (take && dec.ext_words != 2'h0) begin
          state_d = opdec_pkg::ST_EXT1;
        end
      end
      opdec_pkg::ST_EXT1: begin
        if (take) begin
          state_d = hold_long_q ? opdec_pkg::ST_EXT2 : opdec_pkg::ST_OPCODE;
        end
      end
      opdec_pkg::ST_EXT2: begin
        if (take) begin
          state_d = opdec_pkg::ST_OPCODE;
        end
      end
      opdec_pkg::ST_CREXT: begin
        if (take) begin
          state_d = opdec_pkg::ST_OPCODE;
        end
      end
      default: state_d = opdec_pkg::ST_OPCODE;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q     <= opdec_pkg::ST_OPCODE;
      hold_long_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (op_take) begin
        hold_long_q <= (dec.ext_words == 2'h2);
      end
    end
  end

  // ==========================================================
  // Opcode decode outputs, registered on the opcode word; illegal_o also set on a bad control register code
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op_valid_o              <= 1'b0;
      op_word_o               <= 16'h0000;
      halt_o                  <= 1'b0;
      exc_return_o            <= 1'b0;
      sub_return_o            <= 1'b0;
      overflow_trap_o         <= 1'b0;
      return_restore_flags_o  <= 1'b0;
      control_register_move_o <= 1'b0;
      subroutine_jump_o       <= 1'b0;
      unconditional_jump_o    <= 1'b0;
      quick_add_o             <= 1'b0;
      quick_subtract_o        <= 1'b0;
      cond_set_o              <= 1'b0;
      decrement_branch_loop_o <= 1'b0;
      conditional_trap_o      <= 1'b0;
      cond_branch_o           <= 1'b0;
      illegal_o               <= 1'b0;
      condition_o             <= 4'h0;
      quick_data_o            <= 4'h0;
      quick_size_o            <= opdec_pkg::SIZE_BYTE;
      ea_o                    <= 6'h00;
      direction_bit_o         <= 1'b0;
      ext_words_o             <= 2'h0;
    end else begin
      op_valid_o <= op_take;
      if (op_take) begin
        op_word_o               <= word_i;
        halt_o                  <= dec.halt;
        exc_return_o            <= dec.exc_return;
        sub_return_o            <= dec.sub_return;
        overflow_trap_o         <= dec.overflow_trap;
        return_restore_flags_o  <= dec.return_restore_flags;
        control_register_move_o <= dec.control_register_move;
        subroutine_jump_o       <= dec.subroutine_jump;
        unconditional_jump_o    <= dec.unconditional_jump;
        quick_add_o             <= dec.quick_add;
        quick_subtract_o        <= dec.quick_subtract;
        cond_set_o              <= dec.cond_set;
        decrement_branch_loop_o <= dec.decrement_branch_loop;
        conditional_trap_o      <= dec.conditional_trap;
        cond_branch_o           <= dec.cond_branch;
        illegal_o               <= !any_known || dec.bad_field;
        condition_o             <= word_i[11:8];
        quick_data_o            <= q_val;
        quick_size_o            <= opdec_pkg::op_size_t'(word_i[7:6]);
        ea_o                    <= word_i[5:0];
        direction_bit_o         <= word_i[0];
        ext_words_o             <= dec.ext_words;
      end else if (take && state_q == opdec_pkg::ST_CREXT && cr_sel == opdec_pkg::CR_ILLEGAL) begin
        illegal_o               <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Extension words: control selector, word or long data
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_q       <= 32'h0000_0000;
      ext_valid_o <= 1'b0;
      ext_data_o  <= 32'h0000_0000;
      ctl_reg_o   <= opdec_pkg::CR_NONE;
      gen_reg_o   <= 4'h0;
    end else begin
      ext_valid_o <= 1'b0;
      if (take && state_q == opdec_pkg::ST_CREXT) begin
        ctl_reg_o   <= cr_sel;
        gen_reg_o   <= word_i[15:12];
        ext_data_o  <= {16'h0000, word_i};
        ext_valid_o <= 1'b1;
      end else if (take && state_q == opdec_pkg::ST_EXT1) begin
        ext_q[31:16] <= word_i;
        if (!hold_long_q) begin
          ext_data_o  <= {{16{word_i[15]}}, word_i};
          ext_valid_o <= 1'b1;
        end
      end else if (take && state_q == opdec_pkg::ST_EXT2) begin
        ext_data_o  <= {ext_q[31:16], word_i};
        ext_valid_o <= 1'b1;
      end
    end
  end
endmodule

/* File: shared/opdec_pkg.sv */
/*
  Constants and types for the 0100/0110 opcode field decoder.
  Assumes opcode words arrive one per valid cycle from the fetch pipeline.
*/
// Contract
// - For a control register move, bit 0 of the opcode is the direction bit, 0 control-to-general, 1 general-to-control.
// - The control register of a move is chosen by the 12-bit extension code 000,001,002,800..804.
// - The quick add/subtract data field gives 1 to 7 directly and 8 for pattern 000.
// - The quick add/subtract size field is 00 byte, 01 word, 10 long.
// - Conditional set is 0101, condition, bits 7:6 set, then an effective address.
// - Conditional trap opmode 010 takes one extension word, 011 two, 100 none.
// - Conditional branch low byte 00 means a 16-bit word follows, FF a 32-bit one.
package opdec_pkg;
  // ==========================================================
  // Fixed opcode patterns
  localparam logic [15:0] OP_HALT         = 16'h4e72;
  localparam logic [15:0] OP_EXC_RETURN   = 16'h4e73;
  localparam logic [15:0] OP_SUB_RETURN   = 16'h4e75;
  localparam logic [15:0] OP_OVF_TRAP     = 16'h4e76;
  localparam logic [15:0] OP_RET_RESTORE  = 16'h4e77;
  localparam logic [14:0] OP_CRMOVE_HI    = 15'h273d;
  localparam logic [9:0]  OP_SUBJUMP_HI   = 10'h13a;
  localparam logic [9:0]  OP_JUMP_HI      = 10'h13b;
  localparam logic [3:0]  OP_GRP_QUICK    = 4'h5;
  localparam logic [3:0]  OP_GRP_BRANCH   = 4'h6;
  localparam logic [1:0]  OP_SET_BITS     = 2'h3;
  localparam logic [2:0]  OP_LOOP_MODE    = 3'h1;
  localparam logic [2:0]  OP_TRAP_MODE    = 3'h7;
  // ==========================================================
  // Field values
  localparam logic [2:0]  TRAP_OPM_WORD   = 3'h2;
  localparam logic [2:0]  TRAP_OPM_LONG   = 3'h3;
  localparam logic [2:0]  TRAP_OPM_NONE   = 3'h4;
  localparam logic [7:0]  DISP_WORD_CODE  = 8'h00;
  localparam logic [7:0]  DISP_LONG_CODE  = 8'hff;
  localparam logic [2:0]  QUICK_EIGHT_PAT = 3'h0;
  localparam logic [3:0]  QUICK_EIGHT_VAL = 4'h8;
  localparam logic [11:0] CR_SFC_CODE     = 12'h000;
  localparam logic [11:0] CR_DFC_CODE     = 12'h001;
  localparam logic [11:0] CR_CACHE_CODE   = 12'h002;
  localparam logic [11:0] CR_USP_CODE     = 12'h800;
  localparam logic [11:0] CR_VBR_CODE     = 12'h801;
  localparam logic [11:0] CR_CACHE_ADDRESS_CODE    = 12'h802;
  localparam logic [11:0] CR_MSP_CODE     = 12'h803;
  localparam logic [11:0] CR_ISP_CODE     = 12'h804;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2,
    SIZE_BAD  = 2'h3
  } op_size_t;

  typedef enum logic [8:0] {
    CR_NONE      = 9'h000,
    CR_SRC_FC    = 9'h001,
    CR_DST_FC    = 9'h002,
    CR_CACHE     = 9'h004,
    CR_USER_SP   = 9'h008,
    CR_VEC_BASE  = 9'h010,
    CR_CACHE_ADR = 9'h020,
    CR_MASTER_SP = 9'h040,
    CR_INT_SP    = 9'h080,
    CR_ILLEGAL   = 9'h100
  } ctl_reg_t;

  typedef enum logic [3:0] {
    ST_OPCODE = 4'h1,
    ST_EXT1   = 4'h2,
    ST_EXT2   = 4'h4,
    ST_CREXT  = 4'h8
  } dec_state_t;
endpackage

/* File: shared/opdec_if.sv */
/*
  Carries one decoded opcode word between the field matcher and the sequencer.
  Assumes a single clock domain.
*/
`timescale 1ns/1ps
interface opdec_if;
  logic       halt;
  logic       exc_return;
  logic       sub_return;
  logic       overflow_trap;
  logic       return_restore_flags;
  logic       control_register_move;
  logic       subroutine_jump;
  logic       unconditional_jump;
  logic       quick_add;
  logic       quick_subtract;
  logic       cond_set;
  logic       decrement_branch_loop;
  logic       conditional_trap;
  logic       cond_branch;
  logic [1:0] ext_words;
  logic       bad_field;
  modport match (output halt, exc_return, sub_return, overflow_trap, return_restore_flags,
                 control_register_move, subroutine_jump, unconditional_jump, quick_add,
                 quick_subtract, cond_set, decrement_branch_loop, conditional_trap,
                 cond_branch, ext_words, bad_field);
  modport seq   (input halt, exc_return, sub_return, overflow_trap, return_restore_flags,
                 control_register_move, subroutine_jump, unconditional_jump, quick_add,
                 quick_subtract, cond_set, decrement_branch_loop, conditional_trap,
                 cond_branch, ext_words, bad_field);
endinterface

/* File: verilog/opcode_field_match.sv */
/*
  Combinational pattern matcher for one opcode word.
  Assumes the word is stable while word_valid_i is high in the caller.
*/
`timescale 1ns/1ps
module opcode_field_match (
  input  wire logic [15:0] word_i,  // Opcode word
  opdec_if.match           dec      // Match flags
);
  // ==========================================================
  // Fixed patterns matched within the opcode word
  assign dec.halt                  = (word_i == opdec_pkg::OP_HALT);
  assign dec.exc_return            = (word_i == opdec_pkg::OP_EXC_RETURN);
  assign dec.sub_return            = (word_i == opdec_pkg::OP_SUB_RETURN);
  assign dec.overflow_trap         = (word_i == opdec_pkg::OP_OVF_TRAP);
  assign dec.return_restore_flags  = (word_i == opdec_pkg::OP_RET_RESTORE);
  assign dec.control_register_move = (word_i[15:1] == opdec_pkg::OP_CRMOVE_HI);
  assign dec.subroutine_jump       = (word_i[15:6] == opdec_pkg::OP_SUBJUMP_HI);
  assign dec.unconditional_jump    = (word_i[15:6] == opdec_pkg::OP_JUMP_HI);

  // ==========================================================
  // Group 0101 split: set, loop, trap, quick arithmetic; group 0110 branch
  wire quick_grp = (word_i[15:12] == opdec_pkg::OP_GRP_QUICK);
  wire set_bits  = (word_i[7:6] == opdec_pkg::OP_SET_BITS);
  wire loop_mode = (word_i[5:3] == opdec_pkg::OP_LOOP_MODE);
  wire trap_mode = (word_i[5:3] == opdec_pkg::OP_TRAP_MODE);
  assign dec.decrement_branch_loop = quick_grp && set_bits && loop_mode;
  assign dec.conditional_trap      = quick_grp && set_bits && trap_mode;
  assign dec.cond_set              = quick_grp && set_bits && !loop_mode && !trap_mode;
  assign dec.quick_add             = quick_grp && !set_bits && !word_i[8];
  assign dec.quick_subtract        = quick_grp && !set_bits && word_i[8];
  assign dec.cond_branch           = (word_i[15:12] == opdec_pkg::OP_GRP_BRANCH);

  // ==========================================================
  // Extension word count
  wire [2:0] opm       = word_i[2:0];
  wire [7:0] disp8     = word_i[7:0];
  wire       trap_w    = (opm == opdec_pkg::TRAP_OPM_WORD);
  wire       trap_l    = (opm == opdec_pkg::TRAP_OPM_LONG);
  wire       trap_n    = (opm == opdec_pkg::TRAP_OPM_NONE);
  wire       br_word   = (disp8 == opdec_pkg::DISP_WORD_CODE);
  wire       br_long   = (disp8 == opdec_pkg::DISP_LONG_CODE);
  wire       one_ext   = dec.halt || dec.decrement_branch_loop
                         || (dec.conditional_trap && trap_w)
                         || (dec.cond_branch && br_word);
  wire       two_ext   = (dec.conditional_trap && trap_l)
                         || (dec.cond_branch && br_long);
  assign dec.ext_words = two_ext ? 2'h2 : (one_ext ? 2'h1 : 2'h0);
  assign dec.bad_field = (dec.conditional_trap && !trap_w && !trap_l && !trap_n)
                         || ((dec.quick_add || dec.quick_subtract)
                             && (word_i[7:6] == 2'(opdec_pkg::SIZE_BAD)));
endmodule

/* File: testbench/fetch_model.sv */
/*
  Fetch pipeline model: offers opcode and extension words one per valid cycle.
  Assumes the caller orders words as the decoder expects them.
*/
`timescale 1ns/1ps
module fetch_model (
  input  wire logic   clk_i,   // Core clock
  output logic        valid_o, // Word present
  output logic [15:0] word_o   // Opcode or extension word
);
  // Idle until the first word
  initial begin
    valid_o = 1'b0;
    word_o  = 16'h0000;
  end
  // One idle cycle; the released bus inverts its last value, so two idle cycles bring back the last word
  task automatic idle();
    @(negedge clk_i);
    valid_o <= 1'b0;
    word_o  <= ~word_o;
  endtask
  // Optional gap, then one word held for a single cycle
  task automatic put(input logic [15:0] w, input int gap);
    repeat (gap) idle();
    @(negedge clk_i);
    valid_o <= 1'b1;
    word_o  <= w;
  endtask
endmodule

/* File: testbench/opdec_chk.sv */
/*
  Port checker for the opcode field decoder.
  Assumes one clock domain; bound below this module.
*/
`timescale 1ns/1ps
module opdec_chk (
  input wire logic                ref_clk_i,
  input wire logic                resetn_i,
  input wire logic                word_valid_i,
  input wire logic [15:0]         word_i,
  input wire logic                op_valid_o,
  input wire logic [15:0]         op_word_o,
  input wire logic                control_register_move_o,
  input wire logic                quick_add_o,
  input wire logic                quick_subtract_o,
  input wire logic                cond_set_o,
  input wire logic                conditional_trap_o,
  input wire logic                cond_branch_o,
  input wire logic [3:0]          condition_o,
  input wire logic [3:0]          quick_data_o,
  input wire opdec_pkg::op_size_t quick_size_o,
  input wire logic                direction_bit_o,
  input wire opdec_pkg::ctl_reg_t ctl_reg_o,
  input wire logic [3:0]          gen_reg_o,
  input wire logic [1:0]          ext_words_o,
  input wire logic                ext_valid_o,
  input wire logic [31:0]         ext_data_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================
  // Extension words still owed, opcode detect
  logic [1:0]  pend_q;
  wire  [1:0]  pend  = op_valid_o ? ext_words_o + {1'b0, control_register_move_o} : pend_q;
  wire         is_op = word_valid_i && pend == 2'h0;
  wire  [11:0] sel   = ext_data_o[11:0];
  wire  [8:0]  ctl_x = sel <= 12'h002 ? 9'h001 << sel[1:0]
                     : (sel >= 12'h800 && sel <= 12'h804) ? 9'h008 << sel[2:0] : 9'h100;
  wire  [2:0]  opm   = op_word_o[2:0];
  wire  [7:0]  low   = op_word_o[7:0];
  wire         quick = op_valid_o && (quick_add_o || quick_subtract_o);
  // Count down one per extension word taken
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_q <= 2'h0;
    end else begin
      pend_q <= (word_valid_i && pend != 2'h0) ? pend - 2'h1 : pend;
    end
  end
  // ==========================================
  // Assertions
  a_op_pulse: assert property (is_op |=> op_valid_o && op_word_o == $past(word_i))
    else $error("opcode not decoded next cycle");
  a_op_quiet: assert property (!is_op |=> !op_valid_o)
    else $error("decode pulse without opcode");
  a_ext_last: assert property (word_valid_i && pend == 2'h1 |=> ext_valid_o)
    else $error("extension data missing");
  a_ext_first: assert property (word_valid_i && pend == 2'h2 |=> !ext_valid_o)
    else $error("long data released after one word");
  a_dir_bit: assert property (op_valid_o && control_register_move_o |->
    direction_bit_o == op_word_o[0])
    else $error("direction bit wrong");
  a_ctl_select: assert property (ext_valid_o && control_register_move_o |->
    ctl_reg_o == ctl_x && gen_reg_o == ext_data_o[15:12] && ext_data_o[31:16] == 16'h0)
    else $error("control register select wrong");
  a_quick_data: assert property (quick |->
    quick_data_o == {~|op_word_o[11:9], op_word_o[11:9]} && quick_add_o != op_word_o[8])
    else $error("quick immediate wrong");
  a_quick_size: assert property (quick |->
    quick_size_o == op_word_o[7:6] && op_word_o[7:6] != 2'h3)
    else $error("quick size wrong");
  a_set_class: assert property (op_valid_o && op_word_o[15:12] == 4'h5 &&
    low[7:6] == 2'h3 |->
    cond_set_o != (op_word_o[5:3] inside {3'h1, 3'h7}) && condition_o == op_word_o[11:8])
    else $error("conditional set class wrong");
  a_trap_ext: assert property (op_valid_o && conditional_trap_o |->
    ext_words_o == (opm == 3'h2 ? 2'h1 : opm == 3'h3 ? 2'h2 : 2'h0))
    else $error("trap extension count wrong");
  a_branch_ext: assert property (op_valid_o && cond_branch_o |->
    ext_words_o == (low == 8'h00 ? 2'h1 : low == 8'hff ? 2'h2 : 2'h0))
    else $error("branch extension count wrong");
  // Main scenarios reached
  c_long_branch: cover property (op_valid_o && cond_branch_o && ext_words_o == 2'h2);
  c_ctl_move: cover property (ext_valid_o && control_register_move_o);
  c_trap_none: cover property (op_valid_o && conditional_trap_o && ext_words_o == 2'h0);
endmodule
bind opcode_field_decoder opdec_chk opdec_chk_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .word_valid_i(word_valid_i), .word_i(word_i), .op_valid_o(op_valid_o), .op_word_o(op_word_o),
  .control_register_move_o(control_register_move_o), .quick_add_o(quick_add_o),
  .quick_subtract_o(quick_subtract_o), .cond_set_o(cond_set_o), .condition_o(condition_o),
  .conditional_trap_o(conditional_trap_o), .cond_branch_o(cond_branch_o),
  .quick_data_o(quick_data_o), .quick_size_o(quick_size_o), .direction_bit_o(direction_bit_o),
  .ctl_reg_o(ctl_reg_o), .gen_reg_o(gen_reg_o), .ext_words_o(ext_words_o),
  .ext_valid_o(ext_valid_o), .ext_data_o(ext_data_o));

/* File: testbench/opcode_field_decoder_0100_0110_test.sv */
/*
  Self-checking bench for the opcode field decoder.
  Assumes the fetch model and the bound checker beside it.
*/
`timescale 1ns/1ps
module opcode_field_decoder_0100_0110_test;
  logic                      ref_clk_i;
  logic                      resetn_i;
  wire                       wv, ready, op_valid, illegal, dir, ext_valid;
  wire  [15:0]               wd, op_word;
  wire  [13:0]               fl;
  wire  [3:0]                cond, qdata, gen;
  wire  [5:0]                ea;
  wire  [1:0]                ext_words;
  wire  [31:0]               ext_data;
  wire  opdec_pkg::op_size_t qsize;
  wire  opdec_pkg::ctl_reg_t ctl;
  wire  [63:0]               op_seen = {fl, illegal, ext_words, qdata, qsize, dir, cond, ea, op_word};
  logic [63:0]               opq[$], extq[$], e_note, e_got;
  int                        failures = 0, n_compared = 0, cyc = 0;
  logic [11:0]               sels [10] = '{12'h000, 12'h001, 12'h002, 12'h800, 12'h801,
                                           12'h802, 12'h803, 12'h804, 12'h003, 12'h805};
  logic [15:0]               fixed [9] = '{16'h4e72, 16'h4e73, 16'h4e75, 16'h4e76,
                                           16'h4e77, 16'h4e70, 16'h4e74, 16'h4e80, 16'h4ec0};
  // ==========================================
  // Fetch model and decoder
  fetch_model fetch_model_i (.clk_i(ref_clk_i), .valid_o(wv), .word_o(wd));
  opcode_field_decoder opcode_field_decoder_i (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .word_valid_i(wv), .word_i(wd),
    .word_ready_o(ready), .op_valid_o(op_valid), .op_word_o(op_word), .halt_o(fl[13]),
    .exc_return_o(fl[12]), .sub_return_o(fl[11]), .overflow_trap_o(fl[10]),
    .return_restore_flags_o(fl[9]), .control_register_move_o(fl[8]),
    .subroutine_jump_o(fl[7]), .unconditional_jump_o(fl[6]), .quick_add_o(fl[5]),
    .quick_subtract_o(fl[4]), .cond_set_o(fl[3]), .decrement_branch_loop_o(fl[2]),
    .conditional_trap_o(fl[1]), .cond_branch_o(fl[0]), .illegal_o(illegal),
    .condition_o(cond), .quick_data_o(qdata), .quick_size_o(qsize), .ea_o(ea),
    .direction_bit_o(dir), .ctl_reg_o(ctl), .gen_reg_o(gen), .ext_words_o(ext_words),
    .ext_valid_o(ext_valid), .ext_data_o(ext_data));
  // ==========================================
  // Helpers
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [15:0] rw();
    return 16'($urandom);
  endfunction
  function automatic logic [8:0] crx(input logic [11:0] s);
    crx = 9'h100;
    for (int k = 0; k < 8; k++) if (sels[k] == s) crx = 9'h001 << k;
  endfunction
  // Expected flags, illegal, extension count and fields of one opcode
  function automatic logic [63:0] exp_op(input logic [15:0] w, output int n);
    logic        q, s5, db, tr, cb, cm;
    logic [1:0]  x;
    logic [13:0] f;
    q  = w[15:12] == 4'h5;
    s5 = q && w[7:6] == 2'h3;
    db = s5 && w[5:3] == 3'h1;
    tr = s5 && w[5:3] == 3'h7;
    cb = w[15:12] == 4'h6;
    cm = w[15:1] == 15'h273d;
    x  = (w == 16'h4e72 || db || tr && w[2:0] == 3'h2 || cb && w[7:0] == 8'h00) ? 2'h1
       : (tr && w[2:0] == 3'h3 || cb && w[7:0] == 8'hff) ? 2'h2 : 2'h0;
    f  = {w == 16'h4e72, w == 16'h4e73, w == 16'h4e75, w == 16'h4e76, w == 16'h4e77, cm,
          w[15:6] == 10'h13a, w[15:6] == 10'h13b, q && !s5 && !w[8], q && !s5 && w[8],
          s5 && !db && !tr, db, tr, cb};
    n  = x + cm;
    return {f, f == 14'h0 || tr && !(w[2:0] inside {3'h2, 3'h3, 3'h4}), x,
            w[11:9] == 3'h0, w[11:9], w[7:6], w[0], w[11:8], w[5:0], w};
  endfunction
  // Drive one instruction and note what must come out
  task automatic instr(input logic [15:0] w, input logic [15:0] e1, input logic [15:0] e2);
    int         n;
    logic [8:0] x;
    opq.push_back(exp_op(w, n));
    x = crx(e1[11:0]);
    fetch_model_i.put(w, $urandom % 3);
    if (n > 0) fetch_model_i.put(e1, $urandom % 2);
    if (n > 1) fetch_model_i.put(e2, $urandom % 2);
    if (n == 2) extq.push_back({1'b0, 14'h0, e1, e2});
    else if (w[15:1] == 15'h273d) extq.push_back({1'b1, x, e1[15:12], x == 9'h100, 16'h0, e1});
    else if (n == 1) extq.push_back({15'h0, {16{e1[15]}}, e1});
  endtask
  // ==========================================
  // Clock, watchdog, output watcher
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  always @(negedge ref_clk_i) begin
    if (resetn_i && op_valid)
      check(op_seen, opq.size() ? opq.pop_front() : ~op_seen);
    if (resetn_i && ext_valid) begin
      e_note = extq.size() ? extq.pop_front() : '1;
      e_got  = {e_note[46], e_note[46] ? {ctl, gen, illegal} : e_note[45:32], ext_data};
      check(e_got, e_note);
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    logic [15:0] w;
    resetn_i = 1'b0;
    void'($urandom(33));
    repeat (8) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    foreach (fixed[i]) instr(fixed[i] | (i > 6 ? 16'($urandom % 64) : 16'h0), rw(), rw());
    for (int k = 0; k < 20; k++) instr(16'h4e7a | 16'(k % 2), {4'($urandom), sels[k / 2]}, 16'h0);
    for (int i = 0; i < 64; i++) instr({4'h5, 6'(i), 6'($urandom)}, rw(), rw());
    // Trap and loop forms over every condition and opmode
    for (int i = 0; i < 128; i++) begin
      instr({4'h5, 4'(i / 8), 5'h1f, 3'(i)}, rw(), rw());
      instr({4'h5, 4'(i / 8), 5'h19, 3'(i)}, rw(), rw());
    end
    for (int i = 0; i < 16; i++) begin
      instr({4'h6, 4'(i), 8'h00}, rw(), rw());
      instr({4'h6, 4'(i), 8'hff}, rw(), rw());
      instr({4'h6, 4'(i), 8'($urandom)}, rw(), rw());
    end
    // Random words across the decoded groups
    repeat (300) begin
      w = rw();
      w[15:12] = 4'h4 + 4'($urandom % 3);
      if (w[15:12] == 4'h4) w[11:8] = 4'he;
      instr(w, rw(), rw());
    end
    fetch_model_i.idle();
    for (int i = 0; i < 20 && opq.size() + extq.size() > 0; i++) @(negedge ref_clk_i);
    check(64'(opq.size() + extq.size() + !ready), 64'h0);
    summarize();
  end
endmodule
